// ---- timer_pkg.sv ----
// constants shared by the timer channel control logic
package timer_pkg;

  // register reset values and read-only ones
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] PIN_RESET = 8'h88;
  localparam logic [7:0] CTRL_ONES = 8'h80;
  localparam logic [7:0] PIN_ONES = 8'h88;
  localparam logic [15:0] GR_RESET = 16'hffff;
  localparam logic [15:0] CNT_RESET = 16'h0000;

  // counter control field positions
  localparam int CLR_HI = 6;
  localparam int CLR_LO = 5;
  localparam int EDGE_HI = 4;
  localparam int EDGE_LO = 3;
  localparam int CKSEL_HI = 2;
  localparam int CKSEL_LO = 0;

  // pin control field positions
  localparam int FUNC_B_LO = 4;
  localparam int FUNC_A_LO = 0;

  // clear select codes
  localparam logic [1:0] CLR_NONE = 2'h0;
  localparam logic [1:0] CLR_BY_A = 2'h1;
  localparam logic [1:0] CLR_BY_B = 2'h2;
  localparam logic [1:0] CLR_SYNC = 2'h3;

  // general register function codes
  localparam logic [2:0] FN_NO_OUT = 3'h0;
  localparam logic [2:0] FN_OUT_0 = 3'h1;
  localparam logic [2:0] FN_OUT_1 = 3'h2;
  localparam logic [2:0] FN_TOGGLE = 3'h3;
  localparam logic [2:0] FN_CAP_RISE = 3'h4;
  localparam logic [2:0] FN_CAP_FALL = 3'h5;
  localparam logic [2:0] FN_CAP_BOTH = 3'h6;

  // input sync lanes: clocks a..d, then pins a, b
  localparam int SYNC_LANES = 6;
  localparam int LANE_PIN_A = 4;

  // prescaler width, ratios up to 8
  localparam int DIV_WIDTH = 3;
  localparam int PHASE_CHANNEL = 2;
  localparam int PWM_FIRST_CHANNEL = 3;

endpackage

// ---- edge_sync.sv ----
// two-stage input synchroniser with edge detection
`timescale 1ns/1ns
`default_nettype none

module edge_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // raw inputs
  input wire logic [WIDTH-1:0] raw_i,
  // synchronised level and edges
  output logic [WIDTH-1:0] level_o,
  output logic [WIDTH-1:0] rise_o,
  output logic [WIDTH-1:0] fall_o
);

  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] prev_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_nxt;
  logic [WIDTH-1:0] prev_nxt;

  always_comb begin
    meta_nxt = raw_i;
    sync_nxt = meta_r;
    prev_nxt = sync_r;
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign level_o = sync_r;
  assign rise_o = sync_r & ~prev_r;
  assign fall_o = ~sync_r & prev_r;

endmodule

`default_nettype wire

// ---- timer_channel_clock_and_io_control.sv ----
// one timer channel: clock select, counter clear and capture/compare pin control
`timescale 1ns/1ns
`default_nettype none

module timer_channel_clock_and_io_control #(
  parameter int CHANNEL = 0,
  parameter int CNT_WIDTH = 16
) (
  // clock, reset, standby
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic standby_i,
  // control registers
  input wire logic ctrl_write_i,
  input wire logic pin_write_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] ctrl_rdata_o,
  output logic [7:0] pin_rdata_o,
  // general registers and counter
  input wire logic gr_a_write_i,
  input wire logic gr_b_write_i,
  input wire logic [CNT_WIDTH-1:0] gr_wdata_i,
  output logic [CNT_WIDTH-1:0] general_register_a_o,
  output logic [CNT_WIDTH-1:0] general_register_b_o,
  output logic [CNT_WIDTH-1:0] channel_counter_o,
  // mode and synchronisation
  input wire logic phase_count_enable_i,
  input wire logic pwm_mode_i,
  input wire logic channel_sync_select_i,
  input wire logic sync_clear_i,
  output logic sync_clear_o,
  // external clocks
  input wire logic external_clock_input_a_i,
  input wire logic external_clock_input_b_i,
  input wire logic external_clock_input_c_i,
  input wire logic external_clock_input_d_i,
  // capture/compare pins
  input wire logic capture_compare_pin_a_i,
  output logic capture_compare_pin_a_o,
  output logic capture_compare_pin_a_oe_o,
  input wire logic capture_compare_pin_b_i,
  output logic capture_compare_pin_b_o,
  output logic capture_compare_pin_b_oe_o,
  // event flags
  output logic match_capture_flag_a_o,
  output logic match_capture_flag_b_o
);

  localparam logic [CNT_WIDTH-1:0] ONE = CNT_WIDTH'(1);

  logic [timer_pkg::SYNC_LANES-1:0] in_level;
  logic [timer_pkg::SYNC_LANES-1:0] in_rise;
  logic [timer_pkg::SYNC_LANES-1:0] in_fall;

  edge_sync #(
    .WIDTH(timer_pkg::SYNC_LANES)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .raw_i({capture_compare_pin_b_i, capture_compare_pin_a_i,
            external_clock_input_d_i, external_clock_input_c_i,
            external_clock_input_b_i, external_clock_input_a_i}),
    .level_o(in_level),
    .rise_o(in_rise),
    .fall_o(in_fall)
  );

  // registers
  logic [7:0] ctrl_r, ctrl_nxt;
  logic [7:0] pin_r, pin_nxt;
  logic [timer_pkg::DIV_WIDTH-1:0] div_r, div_nxt;
  logic [CNT_WIDTH-1:0] cnt_r, cnt_nxt;
  logic [CNT_WIDTH-1:0] gr_r [2];
  logic [CNT_WIDTH-1:0] gr_nxt [2];
  logic [1:0] match_prev_r, match_prev_nxt;
  logic [1:0] pout_r, pout_nxt;
  logic [1:0] poe_r, poe_nxt;
  logic [1:0] flag_r, flag_nxt;
  logic sync_clr_r, sync_clr_nxt;

  // decoded control
  logic [1:0] clr_sel;
  logic [1:0] edge_sel;
  logic [2:0] ck_sel;
  logic [7:0] pin_eff;
  logic [2:0] fn [2];
  logic [1:0] match_eq;
  logic [1:0] match_hit;
  logic [1:0] capture;
  logic [1:0] event_hit;
  logic [1:0] gr_write;
  logic int_tick;
  logic ext_tick;
  logic tick;
  logic phase_mode;
  logic quad_up;
  logic quad_down;
  logic clear_cnt;

  always_comb begin
    clr_sel = ctrl_r[timer_pkg::CLR_HI:timer_pkg::CLR_LO];
    edge_sel = ctrl_r[timer_pkg::EDGE_HI:timer_pkg::EDGE_LO];
    ck_sel = ctrl_r[timer_pkg::CKSEL_HI:timer_pkg::CKSEL_LO];
    // pwm on channels 3 and 4 overrides pin control
    pin_eff = (CHANNEL >= timer_pkg::PWM_FIRST_CHANNEL && pwm_mode_i) ?
              timer_pkg::PIN_RESET : pin_r;
    fn[0] = pin_eff[timer_pkg::FUNC_A_LO +: 3];
    fn[1] = pin_eff[timer_pkg::FUNC_B_LO +: 3];
    gr_write = {gr_b_write_i, gr_a_write_i};
    // divided clock falling edges as enables
    case (ck_sel[1:0])
      2'h0: int_tick = 1'b1;
      2'h1: int_tick = div_r[0];
      2'h2: int_tick = &div_r[1:0];
      2'h3: int_tick = &div_r;
      default: int_tick = 1'b0;
    endcase
    if (edge_sel[1]) begin
      ext_tick = in_rise[ck_sel[1:0]] | in_fall[ck_sel[1:0]];
    end else if (edge_sel[0]) begin
      ext_tick = in_fall[ck_sel[1:0]];
    end else begin
      ext_tick = in_rise[ck_sel[1:0]];
    end
    tick = ck_sel[2] ? ext_tick : int_tick;
    phase_mode = (CHANNEL == timer_pkg::PHASE_CHANNEL) && phase_count_enable_i;
    quad_up = (in_rise[0] & ~in_level[1]) | (in_fall[0] & in_level[1]) |
              (in_rise[1] & in_level[0]) | (in_fall[1] & ~in_level[0]);
    quad_down = (in_rise[0] & in_level[1]) | (in_fall[0] & ~in_level[1]) |
                (in_rise[1] & ~in_level[0]) | (in_fall[1] & in_level[0]);
    for (int i = 0; i < 2; i++) begin
      match_eq[i] = !fn[i][2] && (cnt_r == gr_r[i]);
      match_hit[i] = match_eq[i] && !match_prev_r[i];
      case (fn[i])
        timer_pkg::FN_CAP_RISE: capture[i] = in_rise[timer_pkg::LANE_PIN_A + i];
        timer_pkg::FN_CAP_FALL: capture[i] = in_fall[timer_pkg::LANE_PIN_A + i];
        timer_pkg::FN_CAP_BOTH: capture[i] = in_rise[timer_pkg::LANE_PIN_A + i] |
                                             in_fall[timer_pkg::LANE_PIN_A + i];
        default: capture[i] = 1'b0;
      endcase
      event_hit[i] = match_hit[i] | capture[i];
    end
    case (clr_sel)
      timer_pkg::CLR_BY_A: clear_cnt = event_hit[0];
      timer_pkg::CLR_BY_B: clear_cnt = event_hit[1];
      timer_pkg::CLR_SYNC: clear_cnt = channel_sync_select_i & sync_clear_i;
      default: clear_cnt = 1'b0;
    endcase
  end

  always_comb begin
    ctrl_nxt = ctrl_r;
    pin_nxt = pin_r;
    div_nxt = div_r + timer_pkg::DIV_WIDTH'(1);
    cnt_nxt = cnt_r;
    match_prev_nxt = match_eq;
    pout_nxt = pout_r;
    poe_nxt = poe_r;
    flag_nxt = event_hit;
    sync_clr_nxt = clear_cnt && (clr_sel != timer_pkg::CLR_SYNC);
    gr_nxt[0] = gr_r[0];
    gr_nxt[1] = gr_r[1];
    if (ctrl_write_i) begin
      ctrl_nxt = reg_wdata_i | timer_pkg::CTRL_ONES;
    end
    if (pin_write_i) begin
      pin_nxt = reg_wdata_i | timer_pkg::PIN_ONES;
    end
    if (clear_cnt) begin
      cnt_nxt = timer_pkg::CNT_RESET;
    end else if (phase_mode) begin
      if (quad_up) begin
        cnt_nxt = cnt_r + ONE;
      end else if (quad_down) begin
        cnt_nxt = cnt_r - ONE;
      end
    end else if (tick) begin
      cnt_nxt = cnt_r + ONE;
    end
    for (int i = 0; i < 2; i++) begin
      if (capture[i]) begin
        gr_nxt[i] = cnt_r;
      end else if (gr_write[i]) begin
        gr_nxt[i] = gr_wdata_i;
      end
      poe_nxt[i] = !fn[i][2] && (fn[i] != timer_pkg::FN_NO_OUT);
      if (match_hit[i]) begin
        case (fn[i])
          timer_pkg::FN_OUT_0: pout_nxt[i] = 1'b0;
          timer_pkg::FN_OUT_1: pout_nxt[i] = 1'b1;
          timer_pkg::FN_TOGGLE: pout_nxt[i] = (CHANNEL == timer_pkg::PHASE_CHANNEL) ?
                                              1'b1 : !pout_r[i];
          default: pout_nxt[i] = pout_r[i];
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || standby_i) begin
      ctrl_r <= timer_pkg::CTRL_RESET;
      pin_r <= timer_pkg::PIN_RESET;
      div_r <= '0;
      cnt_r <= timer_pkg::CNT_RESET;
      gr_r[0] <= timer_pkg::GR_RESET;
      gr_r[1] <= timer_pkg::GR_RESET;
      match_prev_r <= '0;
      pout_r <= '0;
      poe_r <= '0;
      flag_r <= '0;
      sync_clr_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      pin_r <= pin_nxt;
      div_r <= div_nxt;
      cnt_r <= cnt_nxt;
      gr_r[0] <= gr_nxt[0];
      gr_r[1] <= gr_nxt[1];
      match_prev_r <= match_prev_nxt;
      pout_r <= pout_nxt;
      poe_r <= poe_nxt;
      flag_r <= flag_nxt;
      sync_clr_r <= sync_clr_nxt;
    end
  end

  assign ctrl_rdata_o = ctrl_r;
  assign pin_rdata_o = pin_r;
  assign general_register_a_o = gr_r[0];
  assign general_register_b_o = gr_r[1];
  assign channel_counter_o = cnt_r;
  assign sync_clear_o = sync_clr_r;
  assign capture_compare_pin_a_o = pout_r[0];
  assign capture_compare_pin_b_o = pout_r[1];
  assign capture_compare_pin_a_oe_o = poe_r[0];
  assign capture_compare_pin_b_oe_o = poe_r[1];
  assign match_capture_flag_a_o = flag_r[0];
  assign match_capture_flag_b_o = flag_r[1];

  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  a_ctrl_reset_val: assert property (standby_i |=> ctrl_rdata_o == timer_pkg::CTRL_RESET)
    else $error("counter control not at reset value");
  a_pin_reset_val: assert property (standby_i |=> pin_rdata_o == timer_pkg::PIN_RESET)
    else $error("pin control not at reset value");
  a_reserved_ones: assert property (ctrl_rdata_o[7] && pin_rdata_o[7] && pin_rdata_o[3])
    else $error("reserved bit reads zero");
  a_clear_by_a: assert property (!standby_i && clr_sel == timer_pkg::CLR_BY_A && event_hit[0]
                                 |=> channel_counter_o == '0)
    else $error("counter not cleared by a event");
  a_internal_count: assert property (!standby_i && !phase_mode && !clear_cnt && !ck_sel[2]
                                     && ck_sel[1:0] == 2'h0
                                     |=> channel_counter_o == $past(channel_counter_o) + ONE)
    else $error("counter missed internal tick");
  a_capture_store: assert property (!standby_i && capture[1]
                                    |=> general_register_b_o == $past(channel_counter_o)
                                        && match_capture_flag_b_o)
    else $error("capture did not store counter");
  a_match_flag: assert property (!standby_i && match_hit[0] |=> match_capture_flag_a_o)
    else $error("compare match flag missing");
  a_pin_zero_hold: assert property (!capture_compare_pin_a_o && !match_hit[0]
                                    |=> !capture_compare_pin_a_o)
    else $error("pin rose without match");
  a_drive_one: assert property (!standby_i && match_hit[1] && fn[1] == timer_pkg::FN_OUT_1
                                |=> capture_compare_pin_b_o && capture_compare_pin_b_oe_o)
    else $error("pin b not driven high");
  a_toggle_pin: assert property (!standby_i && match_hit[0] && fn[0] == timer_pkg::FN_TOGGLE
                                 |=> capture_compare_pin_a_o ==
                                     ((CHANNEL == timer_pkg::PHASE_CHANNEL) ? 1'b1 :
                                      !$past(capture_compare_pin_a_o)))
    else $error("toggle code wrong");
  a_phase_hold: assert property (!standby_i && phase_mode && !quad_up && !quad_down
                                 && !clear_cnt |=> $stable(channel_counter_o))
    else $error("phase mode counted without edge");

  c_clear_a: cover property (clr_sel == timer_pkg::CLR_BY_A && event_hit[0]);
  c_capture_b: cover property (capture[1]);
  c_toggle: cover property (match_hit[0] && fn[0] == timer_pkg::FN_TOGGLE);
  c_ext_tick: cover property (ck_sel[2] && ext_tick);

endmodule

`default_nettype wire

// ---- far_side_model.sv ----
// far-side model: external clock sources and capture/compare pins
`timescale 1ns/1ns
`default_nettype none
module far_side_model (
  // clock
  input wire logic clk_sys_i,
  // channel pin outputs
  input wire logic pin_a_drv_i,
  input wire logic pin_a_oe_i,
  input wire logic pin_b_drv_i,
  input wire logic pin_b_oe_i,
  // lines seen by the channel
  output logic [3:0] ext_clk_o,
  output logic pin_a_o,
  output logic pin_b_o
);
  logic [3:0] ext_clk_r = 4'h0;
  logic lvl_a_r = 1'b0;
  logic lvl_b_r = 1'b0;
  assign ext_clk_o = ext_clk_r;
  // pin wire: channel wins while it drives
  assign pin_a_o = pin_a_oe_i ? pin_a_drv_i : lvl_a_r;
  assign pin_b_o = pin_b_oe_i ? pin_b_drv_i : lvl_b_r;
  // n full pulses, well above the sync stages
  task automatic pulse_clock(input int idx, input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      ext_clk_r[idx] = 1'b1;
      repeat (4) @(negedge clk_sys_i);
      ext_clk_r[idx] = 1'b0;
      repeat (3) @(negedge clk_sys_i);
    end
  endtask
  // quadrature steps, a leads b: four counts each
  task automatic quad_step(input int n);
    repeat (n) begin
      for (int e = 0; e < 4; e++) begin
        @(negedge clk_sys_i);
        ext_clk_r[e % 2] = (e < 2);
        repeat (4) @(negedge clk_sys_i);
      end
    end
  endtask
  task automatic set_pin(input logic b, input logic lvl);
    @(negedge clk_sys_i);
    if (b) lvl_b_r = lvl;
    else lvl_a_r = lvl;
  endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// testbench for one timer channel control block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic standby_i = 1'b0;
  logic ctrl_write_i = 1'b0;
  logic pin_write_i = 1'b0;
  logic gr_a_write_i = 1'b0;
  logic gr_b_write_i = 1'b0;
  logic sync_sel = 1'b0;
  logic sync_clear_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [15:0] gr_wdata_i = 16'h0000;
  logic [7:0] ctrl_rd;
  logic [7:0] pin_rd;
  logic [15:0] general_register_a;
  logic [15:0] general_register_b;
  logic [15:0] cnt;
  logic [15:0] v;
  logic [3:0] ext_clk;
  logic pa_o, pa_oe, pb_o, pb_oe, pa_in, pb_in, fa, fb;
  logic [15:0] c2_cnt;
  logic sco, c2_pa, c3_pa, c3_oe;
  logic phase_en = 1'b0;
  logic pwm_en = 1'b1;
  logic [4:0] c2_exp = 5'b11011;
  logic [2:0] codes [5] = '{3'h2, 3'h3, 3'h1, 3'h3, 3'h0};
  logic [4:0] pin_exp = 5'b11001;
  logic [4:0] oe_exp = 5'b01111;
  int fail_count = 0;
  int checks_done = 0;
  int i;
  int sel;
  int edg;

  always #10 clk_sys_i = ~clk_sys_i;

  timer_channel_clock_and_io_control #(.CHANNEL(0), .CNT_WIDTH(16)) dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .ctrl_write_i(ctrl_write_i), .pin_write_i(pin_write_i), .reg_wdata_i(reg_wdata_i),
    .ctrl_rdata_o(ctrl_rd), .pin_rdata_o(pin_rd),
    .gr_a_write_i(gr_a_write_i), .gr_b_write_i(gr_b_write_i), .gr_wdata_i(gr_wdata_i),
    .general_register_a_o(general_register_a), .general_register_b_o(general_register_b), .channel_counter_o(cnt),
    .phase_count_enable_i(1'b0), .pwm_mode_i(1'b0),
    .channel_sync_select_i(sync_sel), .sync_clear_i(sync_clear_i), .sync_clear_o(sco),
    .external_clock_input_a_i(ext_clk[0]), .external_clock_input_b_i(ext_clk[1]),
    .external_clock_input_c_i(ext_clk[2]), .external_clock_input_d_i(ext_clk[3]),
    .capture_compare_pin_a_i(pa_in), .capture_compare_pin_a_o(pa_o),
    .capture_compare_pin_a_oe_o(pa_oe),
    .capture_compare_pin_b_i(pb_in), .capture_compare_pin_b_o(pb_o),
    .capture_compare_pin_b_oe_o(pb_oe),
    .match_capture_flag_a_o(fa), .match_capture_flag_b_o(fb)
  );

  far_side_model far_u (
    .clk_sys_i(clk_sys_i), .pin_a_drv_i(pa_o), .pin_a_oe_i(pa_oe),
    .pin_b_drv_i(pb_o), .pin_b_oe_i(pb_oe), .ext_clk_o(ext_clk),
    .pin_a_o(pa_in), .pin_b_o(pb_in)
  );

  // channel 2: phase counting and no toggle
  timer_channel_clock_and_io_control #(.CHANNEL(2), .CNT_WIDTH(16)) dut_ch2_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .ctrl_write_i(ctrl_write_i), .pin_write_i(pin_write_i), .reg_wdata_i(reg_wdata_i),
    .ctrl_rdata_o(), .pin_rdata_o(),
    .gr_a_write_i(gr_a_write_i), .gr_b_write_i(gr_b_write_i), .gr_wdata_i(gr_wdata_i),
    .general_register_a_o(), .general_register_b_o(), .channel_counter_o(c2_cnt),
    .phase_count_enable_i(phase_en), .pwm_mode_i(1'b0),
    .channel_sync_select_i(sync_sel), .sync_clear_i(sync_clear_i), .sync_clear_o(),
    .external_clock_input_a_i(ext_clk[0]), .external_clock_input_b_i(ext_clk[1]),
    .external_clock_input_c_i(ext_clk[2]), .external_clock_input_d_i(ext_clk[3]),
    .capture_compare_pin_a_i(pa_in), .capture_compare_pin_a_o(c2_pa),
    .capture_compare_pin_a_oe_o(),
    .capture_compare_pin_b_i(pb_in), .capture_compare_pin_b_o(),
    .capture_compare_pin_b_oe_o(),
    .match_capture_flag_a_o(), .match_capture_flag_b_o()
  );

  // channel 3: pwm override of pin control
  timer_channel_clock_and_io_control #(.CHANNEL(3), .CNT_WIDTH(16)) dut_ch3_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .ctrl_write_i(ctrl_write_i), .pin_write_i(pin_write_i), .reg_wdata_i(reg_wdata_i),
    .ctrl_rdata_o(), .pin_rdata_o(),
    .gr_a_write_i(gr_a_write_i), .gr_b_write_i(gr_b_write_i), .gr_wdata_i(gr_wdata_i),
    .general_register_a_o(), .general_register_b_o(), .channel_counter_o(),
    .phase_count_enable_i(1'b0), .pwm_mode_i(pwm_en),
    .channel_sync_select_i(sync_sel), .sync_clear_i(sync_clear_i), .sync_clear_o(),
    .external_clock_input_a_i(ext_clk[0]), .external_clock_input_b_i(ext_clk[1]),
    .external_clock_input_c_i(ext_clk[2]), .external_clock_input_d_i(ext_clk[3]),
    .capture_compare_pin_a_i(pa_in), .capture_compare_pin_a_o(c3_pa),
    .capture_compare_pin_a_oe_o(c3_oe),
    .capture_compare_pin_b_i(pb_in), .capture_compare_pin_b_o(),
    .capture_compare_pin_b_oe_o(),
    .match_capture_flag_a_o(), .match_capture_flag_b_o()
  );

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  // kind 0 ctrl, 1 pin, 2 reg a, 3 reg b
  task automatic wr(input int kind, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_wdata_i = d[7:0];
    gr_wdata_i = d;
    ctrl_write_i = (kind == 0);
    pin_write_i = (kind == 1);
    gr_a_write_i = (kind == 2);
    gr_b_write_i = (kind == 3);
    @(negedge clk_sys_i);
    ctrl_write_i = 1'b0;
    pin_write_i = 1'b0;
    gr_a_write_i = 1'b0;
    gr_b_write_i = 1'b0;
  endtask

  task automatic wait_flag(input logic b);
    int k;
    for (k = 0; k < 3000; k++) begin
      @(negedge clk_sys_i);
      if ((b ? fb : fa) === 1'b1) return;
    end
    fail_count++;
    $display("BAD flag wait expected 1 seen 0");
    finish_test();
  endtask

  initial begin
    cyc(1);
    chk("ctrl reset", 16'h0080, {8'h00, ctrl_rd});
    chk("pin reset", 16'h0088, {8'h00, pin_rd});
    chk("count reset", 16'h0000, cnt);
    chk("pins reset", 16'h0000, {14'h0000, pa_o, pb_o});
    cyc(1);
    resetn_i = 1'b1;
    // read-one bits
    wr(0, 16'h002d);
    cyc(1);
    chk("ctrl read", 16'h00ad, {8'h00, ctrl_rd});
    wr(1, 16'h0057);
    cyc(1);
    chk("pin read", 16'h00df, {8'h00, pin_rd});
    wr(1, 16'h0088);
    // internal prescale ratios
    for (i = 0; i < 4; i++) begin
      wr(0, 16'(i));
      cyc(2);
      v = cnt;
      cyc(16);
      chk("internal count", 16'(16 >> i), cnt - v);
    end
    // external inputs a..d rising, then a falling and both
    for (i = 0; i < 6; i++) begin
      sel = (i < 4) ? i : 0;
      edg = (i < 4) ? 0 : i - 3;
      wr(0, 16'(4 + sel + (edg << 3)));
      cyc(2);
      v = cnt;
      far_u.pulse_clock(sel, 3);
      cyc(5);
      chk("external count", (edg == 2) ? 16'h0006 : 16'h0003, cnt - v);
    end
    // reset mid-run so the counter starts below reg a
    resetn_i = 1'b0;
    cyc(2);
    resetn_i = 1'b1;
    chk("count mid reset", 16'h0000, cnt);
    // compare on reg a, clear by a, each output action
    wr(2, 16'h0010);
    chk("reg a write", 16'h0010, general_register_a);
    wr(0, 16'h0020);
    for (i = 0; i < 5; i++) begin
      wr(1, {13'h0011, codes[i]});
      wait_flag(1'b0);
      chk("pin a level", {15'h0000, pin_exp[i]}, {15'h0000, pa_o});
      chk("pin a enable", {15'h0000, oe_exp[i]}, {15'h0000, pa_oe});
      chk("count clear a", 16'h0000, cnt);
      chk("sync clear out", 16'h0001, {15'h0000, sco});
      chk("ch2 pin a level", {15'h0000, c2_exp[i]}, {15'h0000, c2_pa});
      chk("ch3 pin a idle", 16'h0000, {14'h0000, c3_pa, c3_oe});
    end
    // drive one on reg b
    wr(3, 16'h0008);
    chk("reg b write", 16'h0008, general_register_b);
    wr(1, 16'h00a8);
    wait_flag(1'b1);
    chk("pin b drive", 16'h0003, {14'h0000, pb_o, pb_oe});
    // capture on reg b with a stalled counter, clear by b
    wr(1, 16'h0088);
    for (i = 0; i < 3; i++) begin
      wr(0, 16'h0040);
      cyc(5 + i);
      wr(0, 16'h0047);
      cyc(2);
      v = cnt;
      wr(1, 16'(8'hc8 + (i << 4)));
      far_u.set_pin(1'b1, (i != 1));
      wait_flag(1'b1);
      chk("reg b capture", v, general_register_b);
      cyc(1);
      chk("count clear b", 16'h0000, cnt);
    end
    // synchronised clear
    sync_sel = 1'b1;
    wr(0, 16'h0060);
    cyc(4);
    sync_clear_i = 1'b1;
    cyc(3);
    chk("count sync clear", 16'h0000, cnt);
    chk("sync clear out", 16'h0000, {15'h0000, sco});
    sync_clear_i = 1'b0;
    sync_sel = 1'b0;
    // phase counting on channel 2, clock fields ignored
    wr(0, 16'h0000);
    phase_en = 1'b1;
    cyc(2);
    v = c2_cnt;
    far_u.quad_step(2);
    cyc(5);
    chk("ch2 phase count", 16'h0008, c2_cnt - v);
    phase_en = 1'b0;
    // standby entry
    wr(0, 16'h003f);
    wr(1, 16'h0077);
    standby_i = 1'b1;
    cyc(1);
    chk("ctrl standby", 16'h0080, {8'h00, ctrl_rd});
    chk("pin standby", 16'h0088, {8'h00, pin_rd});
    chk("count standby", 16'h0000, cnt);
    standby_i = 1'b0;
    finish_test();
  end
endmodule
`default_nettype wire
